// >>> inc/ssc_defines.vh
// Contract
// R01: port_on enables module and hands over pins
// R02: idle_halt stops module while in Idle
// R03: master enhanced: pending_count counts unsent transfers
// R04: slave enhanced: pending_count counts unread transfers
// R05: shifter_empty high while shift register empty
// R06: word into full receive buffer discarded, overrun
// R07: rx_fifo_empty high while receive FIFO empty
// R08: select 111 interrupts when transmit buffer full
// R09: select 110 interrupts when transmit FIFO empties
// R10: select 101 interrupts when transmission completes
// R11: select 100 interrupts when one word loads
// R12: select 011 interrupts when receive buffer full
// R13: select 010 interrupts when receive three-quarters full
// R14: select 001 interrupts when receive data present
// R15: select 000 interrupts when last entry read
// R16: hardware alone drives the full flags
`ifndef SSC_DEFINES_VH
`define SSC_DEFINES_VH
`define SSC_OFS_STAT 8'h00
`define SSC_OFS_BUF 8'h04
`define SSC_OFS_IRQ_STATUS 8'h08
`define SSC_OFS_IRQ_MASK 8'h0c
`define SSC_OFS_CFG 8'h10
`define SSC_B_PORT_ON 15
`define SSC_B_IDLE_HALT 13
`define SSC_B_SHIFTER_EMPTY 7
`define SSC_B_RX_OVERRUN 6
`define SSC_B_RX_FIFO_EMPTY 5
`define SSC_B_TX_FULL 1
`define SSC_B_RX_FULL 0
`define SSC_B_CFG_MASTER 0
`define SSC_B_CFG_ENH 1
`define SSC_B_IRQ_BUF 0
`define SSC_B_IRQ_OVR 1
`define SSC_FIFO_DEPTH 4'h8
`define SSC_FIFO_3Q 4'h6
`define SSC_LEGACY_DEPTH 4'h1
`define SSC_WORD_BITS 4'h8
`define SSC_DIV_RESET 8'h04
`define SSC_SEL_TX_FULL 3'h7
`define SSC_SEL_TX_EMPTY 3'h6
`define SSC_SEL_TX_DONE 3'h5
`define SSC_SEL_TX_LOAD 3'h4
`define SSC_SEL_RX_FULL 3'h3
`define SSC_SEL_RX_3Q 3'h2
`define SSC_SEL_RX_AVAIL 3'h1
`define SSC_SEL_RX_DRAINED 3'h0
`endif

// >>> design/ssc_spi.v
`include "ssc_defines.vh"

module ssc_spi (
	input wire hclk, // 40 MHz bus clock
	input wire hresetn, // Asynchronous reset, active low
	input wire hsel, // Slave select
	input wire [31:0] haddr, // Byte address
	input wire [1:0] htrans, // Transfer type
	input wire hwrite, // Write when high
	input wire [2:0] hsize, // Transfer size
	input wire [31:0] hwdata, // Write data
	input wire hready, // Bus ready
	output reg hreadyout, // Slave ready
	output reg hresp, // Always OKAY
	output reg [31:0] hrdata, // Read data
	input wire idle_req, // Device is in Idle mode
	input wire sck_i, // Serial clock pin level
	output reg sck_o, // Serial clock drive
	output reg sck_oe, // Serial clock enable
	input wire sdi_i, // Serial data in pin
	output reg sdo_o, // Serial data out
	output reg sdo_oe, // Serial data out enable
	input wire ss_n_i, // Slave select pin, active low
	output reg irq // Level interrupt
);

	reg port_on_r, idle_halt_r, rov_r, master_r, enh_r;
	reg [2:0] isel_r;
	reg [7:0] div_r, divcnt_r;
	reg [1:0] irq_st_r, irq_mask_r;
	reg wr_pend_r;
	reg [7:0] wr_addr_r;
	reg [7:0] txmem [0:7];
	reg [7:0] rxmem [0:7];
	reg [2:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
	reg [3:0] txcnt_r, rxcnt_r;
	reg busy_r;
	reg [3:0] bitcnt_r;
	reg [7:0] shreg_r, rxsh_r;
	reg sck_r;
	reg tx_full_d_r, rx_full_d_r;
	reg [2:0] sck_s_r, sdi_s_r, ss_s_r;
	reg sck_f_r, ss_f_r;
	reg [31:0] rd_data;
	integer i;

	wire ahb_go = hsel & htrans[1] & hready;
	wire ahb_rd = ahb_go & ~hwrite;
	wire [7:0] rd_ofs = haddr[7:0];
	wire [3:0] lim = enh_r ? `SSC_FIFO_DEPTH : `SSC_LEGACY_DEPTH;
	wire halted = ~port_on_r | (idle_halt_r & idle_req); // see R01 see R02
	wire tx_full = (txcnt_r == lim); // see R16
	wire rx_full = (rxcnt_r == lim); // see R16
	wire rx_empty = (rxcnt_r == 4'h0);
	wire sdi_v = sdi_s_r[2];
	wire sck_rise = (sck_s_r[1] == sck_s_r[2]) & sck_s_r[2] & ~sck_f_r;
	wire sck_fall = (sck_s_r[1] == sck_s_r[2]) & ~sck_s_r[2] & sck_f_r;
	wire ss_act = ~ss_f_r & ~master_r;
	wire tick = (divcnt_r == div_r);

	wire tx_push = wr_pend_r & (wr_addr_r == `SSC_OFS_BUF) & port_on_r & ~tx_full;
	wire rx_pop = ahb_rd & (rd_ofs == `SSC_OFS_BUF) & ~rx_empty;
	wire load = ~halted & ~busy_r & (txcnt_r != 4'h0) & (master_r | ~ss_f_r);
	wire m_rise = master_r & busy_r & ~halted & tick & ~sck_r;
	wire m_fall = master_r & busy_r & ~halted & tick & sck_r;
	wire s_smp = ss_act & ~halted & sck_rise;
	wire s_shift = ss_act & ~halted & sck_fall & busy_r & (bitcnt_r != `SSC_WORD_BITS);
	wire sample = m_rise | s_smp;
	wire shift = (m_fall & (bitcnt_r != `SSC_WORD_BITS)) | s_shift;
	wire m_done = m_fall & (bitcnt_r == `SSC_WORD_BITS);
	wire s_done = s_smp & (bitcnt_r == `SSC_WORD_BITS - 4'h1);
	wire done = m_done | s_done;
	wire [7:0] rx_word = master_r ? rxsh_r : {rxsh_r[6:0], sdi_v};
	wire rx_push = done & ~rx_full;
	wire overrun = done & rx_full; // see R06

	reg evt_buf;
	always @*
	begin
		case (isel_r)
			`SSC_SEL_TX_FULL: evt_buf = tx_full & ~tx_full_d_r; // see R08
			`SSC_SEL_TX_EMPTY: evt_buf = load & (txcnt_r == 4'h1) & ~tx_push; // see R09
			`SSC_SEL_TX_DONE: evt_buf = done; // see R10
			`SSC_SEL_TX_LOAD: evt_buf = load; // see R11
			`SSC_SEL_RX_FULL: evt_buf = rx_full & ~rx_full_d_r; // see R12
			`SSC_SEL_RX_3Q: evt_buf = enh_r ? (rxcnt_r >= `SSC_FIFO_3Q) : ~rx_empty; // see R13
			`SSC_SEL_RX_AVAIL: evt_buf = ~rx_empty; // see R14
			`SSC_SEL_RX_DRAINED: evt_buf = rx_pop & (rxcnt_r == 4'h1) & ~rx_push; // see R15
			default: evt_buf = 1'b0;
		endcase
	end

	wire [2:0] pend = master_r ? (txcnt_r > 4'h7 ? 3'h7 : txcnt_r[2:0]) // see R03
		: (rxcnt_r > 4'h7 ? 3'h7 : rxcnt_r[2:0]); // see R04
	wire [15:0] stat_word = {port_on_r, 1'b0, idle_halt_r, 2'b00, pend,
		~busy_r, rov_r, rx_empty, isel_r, tx_full, rx_full}; // see R05 see R07

	always @*
	begin
		rd_data = 32'h0;
		case (rd_ofs)
			`SSC_OFS_STAT: rd_data = {16'h0, stat_word};
			`SSC_OFS_BUF: rd_data = {24'h0, rxmem[rx_rp_r]};
			`SSC_OFS_IRQ_STATUS: rd_data = {30'h0, irq_st_r};
			`SSC_OFS_IRQ_MASK: rd_data = {30'h0, irq_mask_r};
			`SSC_OFS_CFG: rd_data = {16'h0, div_r, 6'h0, enh_r, master_r};
			default: rd_data = 32'h0;
		endcase
	end

	// Bus side: reads decode in the address phase, writes land in the data phase
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0;
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h0;
			port_on_r <= 1'b0;
			idle_halt_r <= 1'b0;
			isel_r <= 3'h0;
			master_r <= 1'b0;
			enh_r <= 1'b0;
			div_r <= `SSC_DIV_RESET;
			irq_mask_r <= 2'h0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_r <= ahb_go & hwrite;
			if (ahb_go)
				wr_addr_r <= rd_ofs;
			if (ahb_rd)
				hrdata <= rd_data;
			if (wr_pend_r)
			begin
				case (wr_addr_r)
					`SSC_OFS_STAT:
					begin
						port_on_r <= hwdata[`SSC_B_PORT_ON]; // see R01
						idle_halt_r <= hwdata[`SSC_B_IDLE_HALT]; // see R02
						isel_r <= hwdata[4:2];
					end
					`SSC_OFS_IRQ_MASK: irq_mask_r <= hwdata[1:0];
					`SSC_OFS_CFG:
					begin
						master_r <= hwdata[`SSC_B_CFG_MASTER];
						enh_r <= hwdata[`SSC_B_CFG_ENH];
						div_r <= hwdata[15:8];
					end
					default: ;
				endcase
			end
		end
	end

	// Pin synchronisers; a level counts once stages two and three agree
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			sck_s_r <= 3'h0;
			sdi_s_r <= 3'h0;
			ss_s_r <= 3'h7;
			sck_f_r <= 1'b0;
			ss_f_r <= 1'b1;
		end
		else
		begin
			sck_s_r <= {sck_s_r[1:0], sck_i};
			sdi_s_r <= {sdi_s_r[1:0], sdi_i};
			ss_s_r <= {ss_s_r[1:0], ss_n_i};
			if (sck_s_r[1] == sck_s_r[2])
				sck_f_r <= sck_s_r[2];
			if (ss_s_r[1] == ss_s_r[2])
				ss_f_r <= ss_s_r[2];
		end
	end

	// FIFOs, shifter and flags
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (i = 0; i < 8; i = i + 1)
			begin
				txmem[i] <= 8'h0;
				rxmem[i] <= 8'h0;
			end
			tx_wp_r <= 3'h0;
			tx_rp_r <= 3'h0;
			rx_wp_r <= 3'h0;
			rx_rp_r <= 3'h0;
			txcnt_r <= 4'h0;
			rxcnt_r <= 4'h0;
			busy_r <= 1'b0;
			bitcnt_r <= 4'h0;
			shreg_r <= 8'h0;
			rxsh_r <= 8'h0;
			sck_r <= 1'b0;
			divcnt_r <= 8'h0;
			rov_r <= 1'b0;
			tx_full_d_r <= 1'b0;
			rx_full_d_r <= 1'b0;
			irq_st_r <= 2'h0;
			irq <= 1'b0;
			sck_o <= 1'b0;
			sck_oe <= 1'b0;
			sdo_o <= 1'b0;
			sdo_oe <= 1'b0;
		end
		else if (!port_on_r)
		begin
			// Disabled: flush and release the pins
			tx_wp_r <= 3'h0;
			tx_rp_r <= 3'h0;
			rx_wp_r <= 3'h0;
			rx_rp_r <= 3'h0;
			txcnt_r <= 4'h0;
			rxcnt_r <= 4'h0;
			busy_r <= 1'b0;
			bitcnt_r <= 4'h0;
			sck_r <= 1'b0;
			divcnt_r <= 8'h0;
			sck_o <= 1'b0;
			sck_oe <= 1'b0; // see R01
			sdo_o <= 1'b0;
			sdo_oe <= 1'b0;
			tx_full_d_r <= 1'b0;
			rx_full_d_r <= 1'b0;
			if (wr_pend_r && wr_addr_r == `SSC_OFS_STAT && !hwdata[`SSC_B_RX_OVERRUN])
				rov_r <= 1'b0;
			if (ahb_rd && rd_ofs == `SSC_OFS_IRQ_STATUS)
				irq_st_r <= 2'h0;
			irq <= |(irq_st_r & irq_mask_r) & ~(ahb_rd && rd_ofs == `SSC_OFS_IRQ_STATUS);
		end
		else
		begin
			tx_full_d_r <= tx_full;
			rx_full_d_r <= rx_full;
			if (tx_push)
			begin
				txmem[tx_wp_r] <= hwdata[7:0];
				tx_wp_r <= tx_wp_r + 3'h1;
			end
			if (load)
				tx_rp_r <= tx_rp_r + 3'h1;
			txcnt_r <= txcnt_r + {3'h0, tx_push} - {3'h0, load};
			if (rx_push)
			begin
				rxmem[rx_wp_r] <= rx_word;
				rx_wp_r <= rx_wp_r + 3'h1;
			end
			if (rx_pop)
				rx_rp_r <= rx_rp_r + 3'h1;
			rxcnt_r <= rxcnt_r + {3'h0, rx_push} - {3'h0, rx_pop};
			// Master clock divider runs only during a word
			if (!master_r || !busy_r || halted || tick)
				divcnt_r <= 8'h0;
			else
				divcnt_r <= divcnt_r + 8'h1;
			if (load)
			begin
				busy_r <= 1'b1;
				bitcnt_r <= 4'h0;
				shreg_r <= txmem[tx_rp_r];
			end
			else if (s_smp && !busy_r)
			begin
				// Slave clocked with nothing queued sends zeros
				busy_r <= 1'b1;
				bitcnt_r <= 4'h1;
				shreg_r <= 8'h0;
				rxsh_r <= {rxsh_r[6:0], sdi_v};
			end
			else if (!master_r && ss_f_r)
			begin
				busy_r <= 1'b0;
				bitcnt_r <= 4'h0;
			end
			else
			begin
				if (sample)
				begin
					rxsh_r <= {rxsh_r[6:0], sdi_v};
					bitcnt_r <= bitcnt_r + 4'h1;
				end
				if (shift)
					shreg_r <= {shreg_r[6:0], 1'b0};
				if (done)
				begin
					busy_r <= 1'b0;
					bitcnt_r <= 4'h0;
				end
			end
			if (m_rise)
				sck_r <= 1'b1;
			else if (m_fall)
				sck_r <= 1'b0;
			sck_o <= sck_r;
			sck_oe <= master_r;
			sdo_o <= shreg_r[7];
			sdo_oe <= master_r | ~ss_f_r;
			// Set wins over a software clear
			if (overrun)
				rov_r <= 1'b1; // see R06
			else if (wr_pend_r && wr_addr_r == `SSC_OFS_STAT && !hwdata[`SSC_B_RX_OVERRUN])
				rov_r <= 1'b0;
			if (ahb_rd && rd_ofs == `SSC_OFS_IRQ_STATUS)
				irq_st_r <= {overrun, evt_buf};
			else
				irq_st_r <= irq_st_r | {overrun, evt_buf};
			irq <= |(({overrun, evt_buf} | (irq_st_r &
				~{2{ahb_rd && rd_ofs == `SSC_OFS_IRQ_STATUS}})) & irq_mask_r);
		end
	end

endmodule // ssc_spi

// >>> tb/ssc_spi_asserts.sv
module ssc_spi_asserts (
	input wire hclk, // Clock
	input wire hresetn, // Reset, active low
	input wire hsel, // Select
	input wire [31:0] haddr, // Address
	input wire [1:0] htrans, // Transfer type
	input wire hwrite, // Write
	input wire hready, // Bus ready
	input wire hreadyout, // Slave ready
	input wire hresp, // Response
	input wire [31:0] hrdata, // Read data
	input wire sck_o, // Clock drive
	input wire sck_oe, // Clock enable
	input wire sdo_o, // Data out
	input wire sdo_oe, // Data enable
	input wire idle_req // Idle mode request
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire rd = hsel && htrans[1] && hready && !hwrite;
	a_zero_wait: assert property (hreadyout)
		else $error("slave inserted a wait state");
	a_resp_okay: assert property (!hresp)
		else $error("slave answered with an error");
	a_pins_paired: assert property (sck_oe |-> sdo_oe)
		else $error("clock driven without data pin");
	// An idle halt may freeze the clock high, so such attempts are dropped
	a_sck_high: assert property (disable iff (!hresetn || idle_req)
		$rose(sck_o) |-> sck_o[*5] ##1 !sck_o)
		else $error("clock high phase not five cycles");
	a_sdo_on_low: assert property (sck_oe && $changed(sdo_o) |-> !sck_o)
		else $error("data changed while clock high");
	a_stat_gaps: assert property (rd && haddr[7:0] == 8'h00 |=>
		hrdata[31:16] == 16'h0 && !hrdata[14] && hrdata[12:11] == 2'h0)
		else $error("unused status bits not zero");
	a_buf_byte: assert property (rd && haddr[7:0] == 8'h04 |=> hrdata[31:8] == 24'h0)
		else $error("buffer read wider than a byte");
	a_irq_bits: assert property (rd && haddr[7:0] == 8'h08 |=> hrdata[31:2] == 30'h0)
		else $error("interrupt status has stray bits");
endmodule // ssc_spi_asserts

bind ssc_spi ssc_spi_asserts ssc_spi_asserts_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .sck_o(sck_o), .sck_oe(sck_oe), .sdo_o(sdo_o),
	.sdo_oe(sdo_oe), .idle_req(idle_req));

// >>> tb/ssc_spi_partner.sv
module ssc_spi_partner (
	input wire sck, // Serial clock from the block
	input wire sdo, // Data from the block
	output logic sdi // Data to the block
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] tx = 8'h00;
	logic [7:0] rx = 8'h00;
	int n = 0;
	logic [7:0] got_q[$];
	initial sdi = 1'b0;
	// Mode 0 slave: sample on rise, next bit on fall, counter byte per word
	always @(posedge sck)
	begin
		rx = {rx[6:0], sdo};
		n = n + 1;
	end
	always @(negedge sck)
	begin
		if (n == 8)
		begin
			got_q.push_back(rx);
			tx = tx + 8'h01;
			n = 0;
		end
		sdi = tx[7 - n];
	end
endmodule // ssc_spi_partner

// >>> tb/ssc_spi_test.sv
module ssc_spi_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, idle_req = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic rd_ph = 1'b0;
	logic sck_pin = 1'b0, ss_pin = 1'b1, slv_sdi = 1'b0;
	wire hreadyout, hresp, irq, sck_o, sck_oe, sdi, sdo_o, sdo_oe;
	wire [31:0] hrdata;
	logic [31:0] e_q[$], m_q[$];
	logic [7:0] sent[0:9];
	int n_errors = 0, n_compared = 0;
	always #12.5 hclk = ~hclk;
	ssc_spi ssc_spi_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .idle_req(idle_req),
		.sck_i(sck_pin), .sck_o(sck_o), .sck_oe(sck_oe), .sdi_i(ss_pin ? sdi : slv_sdi),
		.sdo_o(sdo_o), .sdo_oe(sdo_oe), .ss_n_i(ss_pin), .irq(irq));
	ssc_spi_partner ssc_spi_partner_i (.sck(sck_o & sck_oe), .sdo(sdo_o), .sdi(sdi));
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e)
		begin
			n_errors++;
			$display("Error %0t: got %h want %h", $time, s, e);
		end
	endtask
	task end_sim;
		$display("Errors %0d, compares %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task wait_rdy;
		int i;
		@(posedge hclk);
		for (i = 0; hreadyout !== 1'b1; i++)
		begin
			if (i == 16)
			begin
				n_errors++;
				end_sim;
			end
			@(posedge hclk);
		end
	endtask
	task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		e_q.push_back(e & m);
		m_q.push_back(m);
		bus(a, 1'b0, 32'h0);
	endtask
	// Compare each read data phase with the oldest note
	always @(posedge hclk)
	begin
		if (rd_ph && hreadyout && m_q.size() > 0)
			chk(hrdata & m_q.pop_front(), e_q.pop_front());
		rd_ph <= hsel && htrans[1] && hreadyout && !hwrite;
	end
	initial
	begin
		int s, i, pk;
		logic [31:0] st;
		logic [7:0] b;
		pk = $urandom(32'h5d86);
		pk = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(8'h00, 32'h0, 32'hffffa01c);
		bus(8'h10, 1'b1, 32'h0403);
		bus(8'h14, 1'b1, 32'hffff);
		rd(8'h14, 32'h0, 32'hffffffff);
		for (s = 0; s < 8; s++)
		begin
			st = 32'h8003 | (s << 2) | (s == 2 ? 32'h2000 : 32'h0);
			bus(8'h00, 1'b1, st);
			bus(8'h0c, 1'b1, s == 5 ? 32'h0 : 32'h3);
			idle_req <= (s == 1);
			repeat (3) @(posedge hclk);
			rd(8'h00, st ^ 32'ha3, 32'hffffa7ff);
			rd(8'h08, 32'h0, 32'h0);
			for (i = 0; i < 10; i++)
			begin
				sent[i] = $urandom;
				bus(8'h04, 1'b1, {24'h0, sent[i]});
			end
			rd(8'h00, 32'h0702, 32'h0783);
			if (s == 2)
			begin
				idle_req <= 1'b1;
				repeat (300) @(posedge hclk);
				chk(ssc_spi_partner_i.got_q.size(), 32'h0);
				idle_req <= 1'b0;
			end
			for (i = 0; i < 2000 && ssc_spi_partner_i.got_q.size() < 9; i++)
				@(posedge hclk);
			if (i == 2000)
			begin
				n_errors++;
				end_sim;
			end
			repeat (20) @(posedge hclk);
			chk(irq, s != 5);
			rd(8'h08, s == 0 ? 32'h2 : 32'h3, 32'h3);
			for (i = 0; i < 9; i++)
				chk(ssc_spi_partner_i.got_q.pop_front(), sent[i]);
			for (i = 0; i < 8; i++)
				rd(8'h04, pk + i, 32'hff);
			pk = pk + 9;
			repeat (3) @(posedge hclk);
			rd(8'h00, 32'h00e0, 32'h07e3);
			rd(8'h08, s < 3 ? 32'h1 : 32'h0, 32'h3);
			repeat (3) @(posedge hclk);
			chk(irq, 32'h0);
		end
		// Slave role: one byte clocked in from the pins at a 200 ns link clock
		bus(8'h10, 1'b1, 32'h0402);
		bus(8'h00, 1'b1, 32'h8000);
		b = $urandom;
		ss_pin <= 1'b0;
		repeat (8) @(posedge hclk);
		for (i = 7; i >= 0; i--)
		begin
			slv_sdi <= b[i];
			repeat (4) @(posedge hclk);
			sck_pin <= 1'b1;
			repeat (4) @(posedge hclk);
			sck_pin <= 1'b0;
		end
		repeat (8) @(posedge hclk);
		rd(8'h00, 32'h0180, 32'h07a3);
		rd(8'h04, {24'h0, b}, 32'hff);
		ss_pin <= 1'b1;
		repeat (3) @(posedge hclk);
		end_sim;
	end
endmodule // ssc_spi_test
